/* verilog/flash_cmd_front_end.sv */
/*
  Command front end of a serial flash: SPI framing, status, ID and
  security register commands, write enable latch, volatile status copy.
  Assumes: SCK, CS_N and SI come from another domain and are slow
  against MCLK_I (SCK at least 8 MCLK periods); an executor drains the
  operation FIFO and drives BUSY_I; memory read data follows MEM_* a
  cycle later.
*/
// Overview of operation
// - FFh then FFh in one frame resets continuous read mode.
// - 66h decodes as reset enable, 99h as software reset.
// - B9h powers down; ABh plus three dummies releases and repeats device id.
// - 90h plus address gives maker then device code, order swapped for address 1.
// - 9Fh returns maker, memory type and capacity codes.
// - 5Ah, two zero bytes, address, dummy, then parameter table data stream.
// - 48h, 24-bit address, dummy, then security register data stream.
// - 44h erases and 42h programs a security register.
// - upper byte zero, middle 00h/10h/20h/30h picks register, low byte picks byte.
// - security register 0 is locked; program and erase never touch it.
// - instruction bits sampled on rising SCK; 05h/35h/33h pick status bytes.
// - status byte leaves on SO at falling SCK, most significant bit first.
// - status byte one is readable at any time outside power-down, even while busy.
// - status keeps repeating with fresh values until chip select rises.
// - busy sits in bit 0 of status byte one, 1 while busy.
// - a framed 06h sets the write enable latch.
// - writes, programs and erases need the write enable latch set, except a 01h armed by 50h.
// - volatile status copy loads from non-volatile bits at reset and governs.
// - 50h leaves the latch alone and arms only the next 01h for volatile write.
// - frame starts at chip select fall; first byte is the instruction.
// - write type commands act only if chip select rises on a byte boundary.
// - while busy every command but the 05h status byte one read is ignored.
`timescale 1ns/100ps
module flash_cmd_front_end #(
  parameter logic [7:0] DEVICE_ID = 8'h3C, // arbitrary value
  parameter logic [7:0] MFR_ID = 8'hA5, // arbitrary value
  parameter logic [7:0] MEM_TYPE = 8'h11, // arbitrary value
  parameter logic [7:0] CAPACITY = 8'h22, // arbitrary value
  parameter int unsigned FIFO_WORDS = fcp::FIFO_DEPTH
) (
  input wire logic MCLK_I,
  input wire logic RESET_N_I,
  input wire logic SCK_I,
  input wire logic CS_N_I,
  input wire logic SI_I,
  output logic SO_O,
  output logic SO_OE_O,
  input wire logic BUSY_I,
  input wire fcp::status_t NV_STATUS_I,
  output fcp::status_t STATUS_O,
  output logic NV_STATUS_WR_O,
  output logic WRITE_ENABLE_LATCH_O,
  output logic POWER_DOWN_O,
  output logic SOFT_RESET_O,
  output logic CRM_RESET_O,
  output logic MEM_SFDP_O,
  output logic [1:0] MEM_SEL_O,
  output logic [7:0] MEM_ADDR_O,
  input wire logic [7:0] MEM_RDATA_I,
  output logic OP_VALID_O,
  input wire logic OP_READY_I,
  output fcp::sec_op_t OP_O
);
  typedef struct packed {
    logic [2:0] sck_s;
    logic [2:0] cs_s;
    logic [2:0] si_s;
    logic sck_l;
    logic cs_n_l;
    logic si_l;
    fcp::phase_t ph;
    logic [2:0] bitc;
    logic [7:0] ish;
    logic [7:0] instr;
    logic [2:0] nbytes;
    logic [23:0] addr;
    logic [7:0] osh;
    logic so;
    logic oe;
    logic [1:0] idx;
    logic write_enable_latch;
    logic vol_arm;
    logic rst_arm;
    logic pd;
    logic boot;
    fcp::status_t stat;
    fcp::status_t wdat;
    logic prog_ok;
    logic prog_ovf;
    logic soft_rst;
    logic crm_rst;
    logic nv_wr;
    logic [1:0] msel;
    logic [7:0] maddr;
    logic msfdp;
    logic push;
    fcp::sec_op_t pop;
  } st_t;

  st_t r;
  st_t n;
  logic rise;
  logic fall;
  logic cs_rise;
  logic cs_fall;
  logic [7:0] byte_in;
  logic fifo_ready;
  logic fifo_spare_low;

  // a change counts once the second and third stages agree
  assign rise = (r.sck_s[1] == r.sck_s[2]) && r.sck_s[2] && !r.sck_l;
  assign fall = (r.sck_s[1] == r.sck_s[2]) && !r.sck_s[2] && r.sck_l;
  assign cs_rise = (r.cs_s[1] == r.cs_s[2]) && r.cs_s[2] && !r.cs_n_l;
  assign cs_fall = (r.cs_s[1] == r.cs_s[2]) && !r.cs_s[2] && r.cs_n_l;
  assign byte_in = {r.ish[6:0], r.si_l}; // msb first

  // {valid, register} of a security register address
  function automatic logic [2:0] sec_decode(input logic [23:0] a);
    logic [2:0] res;
    res = 3'h0;
    for (int i = 0; i < fcp::SEC_REGS; i++) begin
      if (a[23:16] == fcp::SEC_UPPER && a[15:8] == fcp::SEC_MID[i]) begin
        res = {1'b1, 2'(i)};
      end
    end
    return res;
  endfunction

  // next byte to send for the running read type command
  function automatic logic [7:0] pick(input logic [7:0] op, input logic [1:0] idx,
                                      input logic swap);
    logic [7:0] s1;
    logic [7:0] res;
    s1 = r.stat.one;
    s1[fcp::BUSY_BIT] = BUSY_I;
    s1[fcp::WEL_BIT] = r.write_enable_latch;
    unique case (op)
      fcp::OPC_STAT1: res = s1;
      fcp::OPC_STAT2: res = r.stat.two;
      fcp::OPC_STAT3: res = r.stat.three;
      fcp::OPC_RELPD: res = DEVICE_ID;
      fcp::OPC_MFRDEV: res = (swap ^ idx[0]) ? DEVICE_ID : MFR_ID;
      fcp::OPC_JID: res = (idx == 2'h0) ? MFR_ID : (idx == 2'h1) ? MEM_TYPE : CAPACITY;
      default: res = MEM_RDATA_I;
    endcase
    return res;
  endfunction

  // whole command engine; SPI runs far slower than MCLK_I, so one
  // decision per sampled edge is enough and no second clock is needed
  always_comb begin
    logic [2:0] sec;
    logic [23:0] a_full;
    logic ena;
    n = r;
    sec = sec_decode({r.addr[15:0], byte_in});
    a_full = {r.addr[15:0], byte_in};
    ena = r.bitc == 3'h0;
    n.soft_rst = 1'b0;
    n.crm_rst = 1'b0;
    n.nv_wr = 1'b0;
    n.push = 1'b0;
    n.sck_s = {r.sck_s[1:0], SCK_I};
    n.cs_s = {r.cs_s[1:0], CS_N_I};
    n.si_s = {r.si_s[1:0], SI_I};
    if (r.sck_s[1] == r.sck_s[2]) n.sck_l = r.sck_s[2];
    if (r.cs_s[1] == r.cs_s[2]) n.cs_n_l = r.cs_s[2];
    if (r.si_s[1] == r.si_s[2]) n.si_l = r.si_s[2];
    if (r.boot) begin
      n.boot = 1'b0;
      n.stat = NV_STATUS_I;
    end
    if (cs_fall) begin
      n.ph = fcp::PH_INSTR;
      n.bitc = 3'h0;
      n.nbytes = 3'h0;
      n.oe = 1'b0;
      n.prog_ok = 1'b0;
      n.prog_ovf = 1'b0;
    end else if (cs_rise) begin
      n.oe = 1'b0;
      if (r.ph != fcp::PH_INSTR) begin
        n.vol_arm = 1'b0;
        n.rst_arm = 1'b0;
        if (ena && r.ph == fcp::PH_ARG) begin
          unique case (r.instr)
            fcp::OPC_WREN: n.write_enable_latch = 1'b1;
            fcp::OPC_WRDIS: n.write_enable_latch = 1'b0;
            fcp::OPC_VOLEN: n.vol_arm = 1'b1;
            fcp::OPC_RSTEN: n.rst_arm = 1'b1;
            fcp::OPC_RST: begin
              if (r.rst_arm) begin
                n.soft_rst = 1'b1;
                n.write_enable_latch = 1'b0;
                n.pd = 1'b0;
                n.stat = NV_STATUS_I;
              end
            end
            fcp::OPC_CRMRST: begin
              n.crm_rst = r.nbytes == 3'h1 && r.addr[7:0] == fcp::OPC_CRMRST;
            end
            fcp::OPC_DPD: n.pd = 1'b1;
            fcp::OPC_WRSTAT: begin
              if (r.nbytes != 3'h0 && (r.vol_arm || r.write_enable_latch)) begin
                n.stat.one = r.wdat.one;
                if (r.nbytes > 3'h1) n.stat.two = r.wdat.two;
                if (r.nbytes > 3'h2) n.stat.three = r.wdat.three;
                if (!r.vol_arm) begin
                  n.nv_wr = 1'b1;
                  n.write_enable_latch = 1'b0;
                end
              end
            end
            fcp::OPC_SECER: begin
              if (r.prog_ok && r.nbytes == fcp::DUMMY_IDX && fifo_ready) begin
                n.push = 1'b1;
                n.pop = '{fcp::OP_ERASE, r.msel, r.maddr, 8'h00};
                n.write_enable_latch = 1'b0;
              end
            end
            fcp::OPC_SECPG: begin
              if (r.prog_ok) begin
                n.push = 1'b1;
                n.pop = '{fcp::OP_COMMIT, r.msel, r.maddr, 8'h00};
                n.write_enable_latch = 1'b0;
                if (r.prog_ovf || r.nbytes <= fcp::DUMMY_IDX) begin
                  n.pop.kind = fcp::OP_ABORT;
                  n.write_enable_latch = r.write_enable_latch;
                end
              end
            end
            default: ;
          endcase
        end else if (r.instr == fcp::OPC_SECPG && r.prog_ok) begin
          n.push = 1'b1; // broken frame: drop the staged bytes
          n.pop = '{fcp::OP_ABORT, r.msel, r.maddr, 8'h00};
        end
      end
    end else if (!r.cs_n_l) begin
      if (rise) begin
        n.ish = byte_in;
        n.bitc = 3'(r.bitc + 3'h1);
        if (r.bitc == fcp::LAST_BIT) begin
          // 90h alternates two codes, so its index wraps after one; 9Fh cycles three
          n.idx = (r.idx == fcp::JID_LAST || (r.instr == fcp::OPC_MFRDEV && r.idx[0])) ?
                  2'h0 : 2'(r.idx + 2'h1);
          unique case (r.ph)
            fcp::PH_INSTR: begin
              n.instr = byte_in;
              n.ph = fcp::PH_ARG;
              n.idx = 2'h1;
              if (r.pd && byte_in != fcp::OPC_RELPD) begin
                n.ph = fcp::PH_SKIP;
              end else if (BUSY_I && byte_in != fcp::OPC_STAT1) begin
                n.ph = fcp::PH_SKIP;
              end else if (byte_in == fcp::OPC_STAT1 || byte_in == fcp::OPC_STAT2 ||
                           byte_in == fcp::OPC_STAT3 || byte_in == fcp::OPC_JID) begin
                n.osh = pick(byte_in, 2'h0, 1'b0);
                n.ph = fcp::PH_OUT;
              end else if (byte_in == fcp::OPC_RELPD) begin
                n.pd = 1'b0;
              end
            end
            fcp::PH_ARG: begin
              if (r.nbytes != fcp::NB_MAX) n.nbytes = 3'(r.nbytes + 3'h1);
              if (r.nbytes <= fcp::ADDR_LAST) n.addr = a_full;
              unique case (r.nbytes)
                3'h0: n.wdat.one = byte_in;
                3'h1: n.wdat.two = byte_in;
                3'h2: n.wdat.three = byte_in;
                default: ;
              endcase
              if (r.nbytes == fcp::ADDR_LAST) begin
                n.maddr = byte_in;
                n.msel = sec[1:0];
                n.msfdp = r.instr == fcp::OPC_SFDP;
                n.idx = 2'h1;
                n.prog_ok = r.write_enable_latch && sec[2] && sec[1:0] != fcp::SEC_LOCKED;
                if (r.instr == fcp::OPC_RELPD || r.instr == fcp::OPC_MFRDEV) begin
                  n.osh = pick(r.instr, 2'h0, byte_in[0]);
                  n.ph = fcp::PH_OUT;
                end
              end else if (r.nbytes == fcp::DUMMY_IDX &&
                           (r.instr == fcp::OPC_SFDP || r.instr == fcp::OPC_SECRD)) begin
                n.osh = MEM_RDATA_I;
                n.maddr = 8'(r.maddr + 8'h01);
                n.ph = fcp::PH_OUT;
              end
              if (r.instr == fcp::OPC_SECPG && r.nbytes >= fcp::DUMMY_IDX && r.prog_ok) begin
                if (fifo_spare_low) begin
                  n.prog_ovf = 1'b1; // keep the last slot for the abort word
                end else if (!r.prog_ovf) begin
                  n.push = 1'b1;
                  n.pop = '{fcp::OP_DATA, r.msel, r.maddr, byte_in};
                  n.maddr = 8'(r.maddr + 8'h01);
                end
              end
            end
            fcp::PH_OUT: begin
              n.osh = pick(r.instr, r.idx, r.addr[0]);
              if (r.instr == fcp::OPC_SFDP || r.instr == fcp::OPC_SECRD) begin
                n.maddr = 8'(r.maddr + 8'h01);
              end
            end
            fcp::PH_SKIP: ;
          endcase
        end
      end
      if (fall && r.ph == fcp::PH_OUT) begin
        n.so = r.osh[7];
        n.osh = {r.osh[6:0], 1'b0};
        n.oe = 1'b1;
      end
    end
  end

  // synchronous reset; the volatile copy loads on the first cycle after
  always_ff @(posedge MCLK_I) begin
    if (!RESET_N_I) begin
      r <= '0;
      r.sck_s <= 3'h0;
      r.cs_s <= 3'h7;
      r.si_s <= 3'h0;
      r.cs_n_l <= 1'b1;
      r.boot <= 1'b1;
    end else begin
      r <= n;
    end
  end

  op_fifo #(
    .WIDTH($bits(fcp::sec_op_t)),
    .DEPTH(FIFO_WORDS)
  ) u_fifo (
    .clk_i(MCLK_I),
    .rst_n_i(RESET_N_I),
    .in_valid_i(r.push),
    .in_ready_o(fifo_ready),
    .in_data_i(r.pop),
    .spare_low_o(fifo_spare_low),
    .out_valid_o(OP_VALID_O),
    .out_ready_i(OP_READY_I),
    .out_data_o(OP_O)
  );

  assign SO_O = r.so;
  assign SO_OE_O = r.oe;
  assign STATUS_O = r.stat;
  assign NV_STATUS_WR_O = r.nv_wr;
  assign WRITE_ENABLE_LATCH_O = r.write_enable_latch;
  assign POWER_DOWN_O = r.pd;
  assign SOFT_RESET_O = r.soft_rst;
  assign CRM_RESET_O = r.crm_rst;
  assign MEM_SFDP_O = r.msfdp;
  assign MEM_SEL_O = r.msel;
  assign MEM_ADDR_O = r.maddr;

  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (!RESET_N_I);

  sequence s_instr_done;
    rise && !r.cs_n_l && r.bitc == fcp::LAST_BIT && r.ph == fcp::PH_INSTR;
  endsequence
  sequence s_end_whole(logic [7:0] op);
    cs_rise && r.ph == fcp::PH_ARG && r.bitc == 3'h0 && r.instr == op;
  endsequence

  a_wren_sets_latch: assert property (s_end_whole(fcp::OPC_WREN) |=> r.write_enable_latch)
    else $error("write enable did not set the latch");
  a_volen_keeps_latch: assert property (s_end_whole(fcp::OPC_VOLEN) |=> $stable(r.write_enable_latch)
    ##1 r.vol_arm)
    else $error("volatile enable touched the latch or failed to arm");
  a_reset_needs_arm: assert property ($rose(r.soft_rst) |-> $past(r.rst_arm))
    else $error("software reset without a preceding reset enable");
  a_busy_in_status: assert property (s_instr_done ##0 byte_in == fcp::OPC_STAT1 && !r.pd
    |=> r.ph == fcp::PH_OUT && r.osh[fcp::BUSY_BIT] == $past(BUSY_I))
    else $error("status byte one lost the busy bit");
  a_busy_ignores: assert property (s_instr_done ##0 BUSY_I && byte_in != fcp::OPC_STAT1
    |=> r.ph == fcp::PH_SKIP)
    else $error("command accepted while busy");
  a_pd_ignores: assert property (s_instr_done ##0 r.pd && byte_in != fcp::OPC_RELPD
    |=> r.ph == fcp::PH_SKIP ##1 r.pd)
    else $error("command accepted in power-down");
  a_partial_ignored: assert property (cs_rise && r.bitc != 3'h0 && r.write_enable_latch
    |=> r.write_enable_latch && !r.nv_wr)
    else $error("write acted on a broken byte");
  a_so_msb_first: assert property (fall && !cs_rise && !r.cs_n_l && r.ph == fcp::PH_OUT
    |=> r.oe && r.so == $past(r.osh[7]))
    else $error("serial output not msb first");
  a_sec_zero_locked: assert property (r.push && r.pop.kind != fcp::OP_ABORT
    |-> r.pop.reg_sel != fcp::SEC_LOCKED)
    else $error("write aimed at locked register 0");
  a_frame_starts: assert property (cs_fall |=> r.ph == fcp::PH_INSTR && r.bitc == 3'h0
    && !r.oe)
    else $error("frame did not restart at chip select fall");
endmodule

/* shared/fcp.sv */
/*
  Shared constants and types of the serial flash command front end:
  instruction codes, status bit places, security register map, FIFO word.
  Assumes: SPI mode 0/3 framing, instructions sent most significant bit first.
*/
package fcp;
  // instruction codes
  localparam logic [7:0] OPC_STAT1 = 8'h05;
  localparam logic [7:0] OPC_STAT2 = 8'h35;
  localparam logic [7:0] OPC_STAT3 = 8'h33;
  localparam logic [7:0] OPC_WREN = 8'h06;
  localparam logic [7:0] OPC_WRDIS = 8'h04;
  localparam logic [7:0] OPC_VOLEN = 8'h50;
  localparam logic [7:0] OPC_WRSTAT = 8'h01;
  localparam logic [7:0] OPC_RSTEN = 8'h66;
  localparam logic [7:0] OPC_RST = 8'h99;
  localparam logic [7:0] OPC_CRMRST = 8'hFF;
  localparam logic [7:0] OPC_DPD = 8'hB9;
  localparam logic [7:0] OPC_RELPD = 8'hAB;
  localparam logic [7:0] OPC_MFRDEV = 8'h90;
  localparam logic [7:0] OPC_JID = 8'h9F;
  localparam logic [7:0] OPC_SFDP = 8'h5A;
  localparam logic [7:0] OPC_SECRD = 8'h48;
  localparam logic [7:0] OPC_SECER = 8'h44;
  localparam logic [7:0] OPC_SECPG = 8'h42;
  // status byte one bit places
  localparam int unsigned BUSY_BIT = 0;
  localparam int unsigned WEL_BIT = 1;
  // byte and argument counting
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [2:0] ADDR_LAST = 3'h2;
  localparam logic [2:0] DUMMY_IDX = 3'h3;
  localparam logic [2:0] NB_MAX = 3'h7;
  localparam logic [1:0] JID_LAST = 2'h2;
  // security register addressing and operation FIFO depth
  localparam int unsigned SEC_REGS = 4;
  localparam logic [7:0] SEC_UPPER = 8'h00;
  localparam logic [7:0] SEC_MID [SEC_REGS] = '{8'h00, 8'h10, 8'h20, 8'h30};
  localparam logic [1:0] SEC_LOCKED = 2'h0;
  localparam int unsigned FIFO_DEPTH = 16;

  typedef enum logic [1:0] {PH_INSTR, PH_ARG, PH_OUT, PH_SKIP} phase_t;
  typedef enum logic [1:0] {OP_ERASE, OP_DATA, OP_COMMIT, OP_ABORT} op_kind_t;
  typedef struct packed {
    op_kind_t kind;
    logic [1:0] reg_sel;
    logic [7:0] offset;
    logic [7:0] data;
  } sec_op_t;
  typedef struct packed {
    logic [7:0] three;
    logic [7:0] two;
    logic [7:0] one;
  } status_t;
endpackage

/* verilog/op_fifo.sv */
/*
  Flip-flop FIFO carrying security register operations to the executor.
  Assumes one clock; spare_low_o warns while at most one free slot is left.
*/
`timescale 1ns/100ps
module op_fifo #(
  parameter int unsigned WIDTH = 20,
  parameter int unsigned DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic spare_low_o,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int unsigned AW = $clog2(DEPTH);
  localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);
  localparam logic [AW:0] CNT_FULL = (AW + 1)'(DEPTH);
  localparam logic [AW:0] CNT_SPARE = (AW + 1)'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } fifo_st_t;

  fifo_st_t r;
  fifo_st_t n;
  logic wr;
  logic rd;

  // handshakes are combinational, the word itself comes from flops
  assign in_ready_o = r.cnt != CNT_FULL;
  assign out_valid_o = r.cnt != '0;
  assign spare_low_o = r.cnt >= CNT_SPARE;
  assign out_data_o = r.mem[r.rp];
  assign wr = in_valid_i && in_ready_o;
  assign rd = out_valid_o && out_ready_i;

  // pointers wrap by compare so any depth works
  always_comb begin
    n = r;
    if (wr) begin
      n.mem[r.wp] = in_data_i;
      n.wp = (r.wp == PTR_LAST) ? '0 : AW'(r.wp + 1'b1);
    end
    if (rd) begin
      n.rp = (r.rp == PTR_LAST) ? '0 : AW'(r.rp + 1'b1);
    end
    if (wr && !rd) begin
      n.cnt = (AW + 1)'(r.cnt + 1'b1);
    end else if (rd && !wr) begin
      n.cnt = (AW + 1)'(r.cnt - 1'b1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
endmodule

/* verification/spi_host.sv */
/*
  Behavioural host SPI controller in mode 0 for the flash front end bench.
  Assumes clk_i is the 50 MHz bench clock; SCK half period is 4 cycles.
*/
`timescale 1ns/100ps
module spi_host (
  input wire logic clk_i,
  input wire logic so_i,
  output logic sck_o,
  output logic cs_n_o,
  output logic si_o
);
  // link idle: clock low and still, device deselected
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
  end

  // one frame: tx bytes, then nrd bytes read back, then nx loose bits
  task automatic frame(input logic [7:0] tx[$], input int nrd, input int nx,
                       output logic [7:0] rx[$]);
    logic [7:0] b;
    logic [7:0] r;
    rx = {};
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    for (int j = 0; j < 8 * (tx.size() + nrd) + nx; j++) begin
      b = (j / 8 < tx.size()) ? tx[j / 8] : 8'h00;
      si_o <= b[7 - j % 8];
      repeat (4) @(posedge clk_i);
      sck_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      // sampled late in the high phase: the slow device output is settled
      r = {r[6:0], so_i};
      sck_o <= 1'b0;
      if (j % 8 == 7 && j / 8 >= tx.size()) begin
        rx.push_back(r);
      end
    end
    repeat (4) @(posedge clk_i);
    cs_n_o <= 1'b1;
    si_o <= ~si_o; // released line must not keep a stale level
    repeat (12) @(posedge clk_i);
  endtask
endmodule

/* verification/testbench.sv */
/*
  Bench of the flash command front end: frames from the host model,
  stand-ins for memory and executor, checks at the ports.
  Assumes the fcp package and the host model spi_host.
*/
`timescale 1ns/100ps
module testbench;
  localparam fcp::status_t NV = 24'h41029C;
  localparam logic [7:0] DID = 8'h5D; // arbitrary value
  localparam logic [7:0] MID = 8'hC3; // arbitrary value
  localparam logic [7:0] MT = 8'h40; // arbitrary value
  localparam logic [7:0] CAP = 8'h17; // arbitrary value
  logic clk, rst_n, busy, rdy, sck, cs_n, si, so, write_enable_latch, pd, srst, crm, sf, opv, oe, nvw;
  logic [1:0] sel;
  logic [7:0] ma, rd;
  fcp::status_t st;
  fcp::sec_op_t op;
  fcp::sec_op_t ops[$];
  logic [7:0] rx[$];
  logic [7:0] q[$];
  int mismatches, check_count, n_srst, n_crm, n_nvw, cyc;

  flash_cmd_front_end #(.DEVICE_ID(DID), .MFR_ID(MID), .MEM_TYPE(MT), .CAPACITY(CAP)) dut_u (
    .MCLK_I(clk), .RESET_N_I(rst_n), .SCK_I(sck), .CS_N_I(cs_n), .SI_I(si), .SO_O(so),
    .SO_OE_O(oe), .BUSY_I(busy), .NV_STATUS_I(NV), .STATUS_O(st), .NV_STATUS_WR_O(nvw),
    .WRITE_ENABLE_LATCH_O(write_enable_latch), .POWER_DOWN_O(pd), .SOFT_RESET_O(srst), .CRM_RESET_O(crm),
    .MEM_SFDP_O(sf), .MEM_SEL_O(sel), .MEM_ADDR_O(ma), .MEM_RDATA_I(rd), .OP_VALID_O(opv),
    .OP_READY_I(rdy), .OP_O(op));

  // an undriven output shows the inverse of its last bit, so a late enable reads wrong
  spi_host host_u (.clk_i(clk), .so_i(oe ? so : ~so), .sck_o(sck), .cs_n_o(cs_n), .si_o(si));

  // memory pattern: parameter space marks bit 7, else register number in bits 6:5
  function automatic logic [7:0] mem(input logic s, input logic [1:0] r, input logic [7:0] a);
    return s ? (8'h80 ^ a) : ({1'b0, r, 5'h00} ^ a);
  endfunction

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask

  task automatic chkop(input fcp::sec_op_t got, input fcp::sec_op_t exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic fr(input logic [7:0] tx[$], input int nrd = 0, input int nx = 0);
    host_u.frame(tx, nrd, nx, rx);
  endtask

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // executor and memory stand-ins, pulse counters; the limit cuts a hang short
  always @(posedge clk) begin
    rd <= mem(sf, sel, ma);
    if (opv && rdy) ops.push_back(op);
    if (srst) n_srst++;
    if (crm) n_crm++;
    if (nvw) n_nvw++;
    cyc++;
    if (cyc == 30000) begin
      mismatches++;
      stop_test();
    end
  end

  initial begin
    rst_n = 1'b0;
    busy = 1'b0;
    rdy = 1'b1;
    mismatches = 0;
    check_count = 0;
    n_srst = 0;
    n_crm = 0;
    n_nvw = 0;
    cyc = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    chk8(st.three, NV.three);
    repeat (6) @(posedge clk);
    fr({fcp::OPC_STAT2}, 2);
    chk8(rx[1], NV.two);
    fr({fcp::OPC_STAT3}, 1);
    chk8(rx[0], NV.three);
    // busy rises while the first byte shifts out: only the second may show it
    fork
      fr({fcp::OPC_STAT1}, 2);
      begin
        repeat (100) @(posedge clk);
        busy <= 1'b1;
      end
    join
    chk8(rx[0], {NV.one[7:2], 2'h0});
    chk8(rx[1], {NV.one[7:2], 2'h1});
    fr({fcp::OPC_WREN});
    chk1(write_enable_latch, 1'b0);
    fr({fcp::OPC_STAT1}, 1);
    chk8(rx[0], {NV.one[7:2], 2'h1});
    busy <= 1'b0;
    fr({fcp::OPC_WRSTAT, 8'h00, 8'h00, 8'h00});
    chk8(st.two, NV.two);
    fr({fcp::OPC_VOLEN});
    chk1(write_enable_latch, 1'b0);
    fr({fcp::OPC_WRSTAT, 8'hFC, 8'h06, 8'h52});
    chk8(st.three, 8'h52);
    fr({fcp::OPC_RST});
    chk8(8'(n_srst), 8'h00);
    fr({fcp::OPC_RSTEN});
    fr({fcp::OPC_RST});
    chk8(8'(n_srst), 8'h01);
    chk8(st.three, NV.three);
    fr({fcp::OPC_CRMRST, fcp::OPC_CRMRST});
    chk8(8'(n_crm), 8'h01);
    fr({fcp::OPC_WREN});
    fr({fcp::OPC_WRDIS});
    chk1(write_enable_latch, 1'b0);
    fr({fcp::OPC_WREN});
    fr({fcp::OPC_WRSTAT, 8'h55}, 0, 3);
    chk1(write_enable_latch, 1'b1);
    chk8(st.one, NV.one);
    fr({fcp::OPC_WRSTAT, 8'hA8});
    chk8(st.one, 8'hA8);
    chk8(8'(n_nvw), 8'h01);
    chk1(write_enable_latch, 1'b0);
    fr({fcp::OPC_JID}, 4);
    chk8(rx[0], MID);
    chk8(rx[1], MT);
    chk8(rx[2], CAP);
    chk8(rx[3], MID);
    chk1(oe, 1'b0);
    for (int a = 0; a < 2; a++) begin
      fr({fcp::OPC_MFRDEV, 8'h00, 8'h00, 8'(a)}, 3);
      chk8(rx[0], (a == 1) ? DID : MID);
      chk8(rx[1], (a == 1) ? MID : DID);
      chk8(rx[2], (a == 1) ? DID : MID);
    end
    fr({fcp::OPC_DPD});
    fr({fcp::OPC_JID}, 1);
    chk1(pd, 1'b1);
    fr({fcp::OPC_RELPD, 8'h00, 8'h00, 8'h00}, 2);
    chk8(rx[1], DID);
    chk1(pd, 1'b0);
    fr({fcp::OPC_SECRD, 8'h00, 8'h10, 8'h03, 8'h00}, 2);
    chk8(rx[0], mem(1'b0, 2'h1, 8'h03));
    chk8(rx[1], mem(1'b0, 2'h1, 8'h04));
    fr({fcp::OPC_SFDP, 8'h00, 8'h00, 8'h08, 8'h00}, 1);
    chk8(rx[0], mem(1'b1, 2'h0, 8'h08));
    fr({fcp::OPC_WREN});
    chk1(write_enable_latch, 1'b1);
    fr({fcp::OPC_SECPG, 8'h00, 8'h10}, 0, 3);
    chk1(write_enable_latch, 1'b1);
    ops = {};
    fr({fcp::OPC_SECPG, 8'h00, 8'h10, 8'h05, 8'hAA});
    fr({fcp::OPC_SECPG, 8'h00, 8'h20, 8'h05, 8'hAA});
    fr({fcp::OPC_WREN});
    fr({fcp::OPC_SECER, 8'h00, 8'h00, 8'h07});
    fr({fcp::OPC_WREN});
    fr({fcp::OPC_SECER, 8'h00, 8'h20, 8'h07});
    chk8(8'(ops.size()), 8'h03);
    chkop(ops[0], {fcp::OP_DATA, 2'h1, 8'h05, 8'hAA});
    chk8(8'(ops[1].kind), 8'(fcp::OP_COMMIT));
    chk8({2'h0, ops[2].kind, 2'h0, ops[2].reg_sel}, {2'h0, fcp::OP_ERASE, 4'h2});
    // executor stalls while a long program fills the buffer until it refuses
    rdy <= 1'b0;
    fr({fcp::OPC_WREN});
    ops = {};
    q = {fcp::OPC_SECPG, 8'h00, 8'h30, 8'h00};
    for (int k = 0; k < 16; k++) q.push_back(8'h10 + 8'(k));
    fr(q);
    chk8(8'(ops.size()), 8'h00);
    rdy <= 1'b1;
    repeat (40) @(posedge clk);
    chk8(8'(ops.size()), 8'h10);
    chkop(ops[14], {fcp::OP_DATA, 2'h3, 8'h0E, 8'h1E});
    chk8(8'(ops[15].kind), 8'(fcp::OP_ABORT));
    stop_test();
  end
endmodule
